// ---- include/gpib_defs.vh ----
// Constants for the instrument bus device interface.
`ifndef GPIB_DEFS_VH
`define GPIB_DEFS_VH

// Register word indices; the byte address is four times the index.
`define GPIB_A_CTRL 4'h0
`define GPIB_A_STAT 4'h1
`define GPIB_A_RXD 4'h2
`define GPIB_A_TXD 4'h3
`define GPIB_A_MASK 4'h4
`define GPIB_A_COND 4'h5
`define GPIB_A_ADDR 4'h6
// Address fields.
`define GPIB_ADDR_FACT 5'h13
`define GPIB_ADDR_LON 5'h1F
// Command bytes received with attention asserted.
`define GPIB_CMD_GTL 7'h01
`define GPIB_CMD_SDC 7'h04
`define GPIB_CMD_LLO 7'h11
`define GPIB_CMD_DCL 7'h14
`define GPIB_CMD_SPE 7'h18
`define GPIB_CMD_SPD 7'h19
`define GPIB_CMD_UNL 7'h3F
`define GPIB_CMD_UNT 7'h5F
`define GPIB_GRP_LAG 2'h1
`define GPIB_GRP_TAG 2'h2
// Status byte.
`define GPIB_RQS_BIT 6
`define GPIB_NCOND 7
// Control register bits.
`define GPIB_C_ADDR_WR 0
`define GPIB_C_SVC 1
`define GPIB_C_TXGO 2
`define GPIB_C_EOI 3
`define GPIB_C_ADDR_LSB 8

`endif

// ---- core/gpib_hs_rx.v ----
// Acceptor handshake: takes one byte from the bus per three-wire cycle.
`timescale 1ns/1ps
module gpib_hs_rx (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire enable,
  input wire dav_n,
  input wire [7:0] dio_n,
  input wire atn_n,
  input wire take,
  output reg nrfd_oe,
  output reg ndac_oe,
  output reg [7:0] byte_r,
  output reg cmd_r,
  output reg full_r
);
  localparam S_RDY = 2'h0;
  localparam S_ACC = 2'h1;
  localparam S_DONE = 2'h2;
  reg [1:0] st_r;

  // ------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------
  // NRFD is held low while a data byte waits, so a slow consumer stalls the talker.
  // A command is never held off: it overwrites an unread data byte, which a clear drops anyway.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_RDY;
      byte_r <= 8'h00;
      cmd_r <= 1'b0;
      full_r <= 1'b0;
      nrfd_oe <= 1'b0;
      ndac_oe <= 1'b0;
    end else if (ce) begin
      if (take)
        full_r <= 1'b0;
      if (!enable) begin
        st_r <= S_RDY;
        nrfd_oe <= 1'b0;
        ndac_oe <= 1'b0;
      end else begin
        case (st_r)
          S_RDY: begin
            ndac_oe <= 1'b1;
            nrfd_oe <= full_r & ~take & atn_n;
            if (!dav_n && !(full_r && !take && atn_n)) begin
              byte_r <= ~dio_n;
              cmd_r <= ~atn_n;
              full_r <= 1'b1;
              nrfd_oe <= 1'b1;
              st_r <= S_ACC;
            end
          end
          S_ACC: begin
            ndac_oe <= 1'b0;
            st_r <= S_DONE;
          end
          S_DONE: begin
            if (dav_n) begin
              ndac_oe <= 1'b1;
              st_r <= S_RDY;
            end
          end
          default: st_r <= S_RDY;
        endcase
      end
    end
  end
endmodule // gpib_hs_rx

// ---- core/gpib_hs_tx.v ----
// Source handshake: puts one byte on the bus per three-wire cycle.
`timescale 1ns/1ps
module gpib_hs_tx (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire enable,
  input wire go,
  input wire [7:0] data,
  input wire eoi,
  input wire nrfd_n,
  input wire ndac_n,
  output reg dav_oe,
  output reg eoi_oe,
  output reg [7:0] dio_oe,
  output wire busy
);
  localparam S_IDLE = 2'h0;
  localparam S_WRDY = 2'h1;
  localparam S_WACC = 2'h2;
  reg [1:0] st_r;
  assign busy = (st_r != S_IDLE);

  // ------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------
  // Losing enable (unaddressed, clear or abort) drops the lines at once.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_IDLE;
      dav_oe <= 1'b0;
      eoi_oe <= 1'b0;
      dio_oe <= 8'h00;
    end else if (ce) begin
      if (!enable) begin
        st_r <= S_IDLE;
        dav_oe <= 1'b0;
        eoi_oe <= 1'b0;
        dio_oe <= 8'h00;
      end else begin
        case (st_r)
          S_IDLE: begin
            if (go) begin
              dio_oe <= data;
              eoi_oe <= eoi;
              st_r <= S_WRDY;
            end
          end
          S_WRDY: begin
            if (nrfd_n) begin
              dav_oe <= 1'b1;
              st_r <= S_WACC;
            end
          end
          S_WACC: begin
            if (ndac_n) begin
              dav_oe <= 1'b0;
              eoi_oe <= 1'b0;
              dio_oe <= 8'h00;
              st_r <= S_IDLE;
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule // gpib_hs_tx

// ---- core/gpib_dev.v ----
// Instrument bus device interface with AHB-Lite register access.
// Behaviour
// - Addresses 00 to 30 are normal addresses.
// - Address 31 selects listen-only, panel stays live.
// - Factory address 19 in store and switch.
// - Stored address survives while backup power holds; addr_r still resets to factory 19.
// - Store lost: take switch address at power-on.
// - Panel address change in service mode drops control.
// - Remote state ignores panel except local key.
// - Listen addressed with REN: untalk, accept data.
// - Talk addressed: unlisten, may send data.
// - Selected clear when listening: untalk, discard input; code needs REN as well.
// - Universal clear: untalk, discard input.
// - Go-to-local when listening: untalk, go local; code needs REN as well.
// - Local lockout disables the local key.
// - Clear lockout: enable local key, go local.
// - Service request possible in any state except listen-only.
// - Serial poll plus talk address sends status.
// - Interface clear leaves talker and listener states.
// - Local state keeps requests, status, talk data.
// - Remote only with REN, after first listen address.
// - Request line only for masked-in pending conditions.
// - Eight-bit status byte, bit 6 request sent.
// - Device clear leaves instrument parameters alone.
`timescale 1ns/1ps
`include "gpib_defs.vh"
module gpib_dev #(
  parameter NCOND = `GPIB_NCOND
) (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire backup_valid,
  input wire [4:0] addr_switch,
  input wire local_key,
  input wire [NCOND-1:0] cond_set,
  input wire [7:0] dio_n_in,
  output wire [7:0] dio_n_out,
  output wire [7:0] dio_n_oe,
  input wire dav_n_in,
  output wire dav_n_out,
  output wire dav_n_oe,
  input wire nrfd_n_in,
  output wire nrfd_n_out,
  output wire nrfd_n_oe,
  input wire ndac_n_in,
  output wire ndac_n_out,
  output wire ndac_n_oe,
  input wire eoi_n_in,
  output wire eoi_n_out,
  output wire eoi_n_oe,
  input wire atn_n,
  input wire ifc_n,
  input wire ren_n,
  output wire srq_n_out,
  output wire srq_n_oe,
  output wire remote,
  output wire listen,
  output wire talk,
  output wire panel_enable,
  output reg dev_clear,
  output reg svc_ctrl_en
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [4:0] addr_r;
  reg loaded_r;
  reg lads_r;
  reg tads_r;
  reg spms_r;
  reg rem_r;
  reg llo_r;
  reg rqs_r;
  reg svc_mode_r;
  reg [7:0] txd_r;
  reg tx_eoi_r;
  reg tx_go_r;
  reg [NCOND-1:0] cond_r;
  reg [NCOND-1:0] mask_r;
  reg sb_sent_r;
  wire [7:0] rx_byte;
  wire rx_cmd;
  wire rx_full;
  wire tx_busy;
  wire rx_take;
  wire dav_oe;
  wire eoi_oe;
  wire [7:0] tx_dio_oe;
  wire nrfd_oe;
  wire ndac_oe;
  wire lon = (addr_r == `GPIB_ADDR_LON);
  wire ren = ~ren_n;
  wire ifc = ~ifc_n;
  wire ifc_eff = ifc & ~lon;
  wire ren_eff = ren & ~lon;
  wire listen_w = lads_r | lon;
  wire [7:0] stb = {cond_r[NCOND-1], rqs_r, cond_r[5:0]};
  wire srq_want = |(cond_r & mask_r);

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  reg wr_ph_r;
  reg [3:0] wa_r;
  wire acc = hsel & htrans[1] & hready;
  wire [3:0] aidx = haddr[5:2];
  wire wr = wr_ph_r;
  wire addr_wr = wr & (wa_r == `GPIB_A_CTRL) & hwdata[`GPIB_C_ADDR_WR];
  wire rxd_rd = acc & ~hwrite & (aidx == `GPIB_A_RXD);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      wa_r <= 4'h0;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      wr_ph_r <= acc & hwrite;
      wa_r <= aidx;
      if (acc && !hwrite) begin
        case (aidx)
          `GPIB_A_STAT: hrdata <= {22'h0, svc_ctrl_en, tx_busy, rx_cmd, rx_full,
                                   llo_r, rem_r, spms_r, lon, tads_r, lads_r};
          `GPIB_A_RXD: hrdata <= {24'h0, rx_byte};
          `GPIB_A_TXD: hrdata <= {24'h0, txd_r};
          `GPIB_A_MASK: hrdata <= {{(32-NCOND){1'b0}}, mask_r};
          `GPIB_A_COND: hrdata <= {24'h0, stb};
          `GPIB_A_ADDR: hrdata <= {27'h0, addr_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Address store and software-side registers
  // ------------------------------------------------------------
  // The address lives in backed-up storage outside; this copy keeps its reset
  // value, the factory address, while backup_valid holds, or loads the switch when the backup was lost.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= `GPIB_ADDR_FACT;
      loaded_r <= 1'b0;
      svc_mode_r <= 1'b0;
      svc_ctrl_en <= 1'b0;
      txd_r <= 8'h00;
      tx_eoi_r <= 1'b0;
      tx_go_r <= 1'b0;
      mask_r <= {NCOND{1'b0}};
    end else if (ce) begin
      tx_go_r <= 1'b0;
      if (!loaded_r) begin
        loaded_r <= 1'b1;
        if (!backup_valid)
          addr_r <= addr_switch;
      end
      if (wr && wa_r == `GPIB_A_CTRL) begin
        svc_mode_r <= hwdata[`GPIB_C_SVC];
        tx_eoi_r <= hwdata[`GPIB_C_EOI];
        tx_go_r <= hwdata[`GPIB_C_TXGO];
        svc_ctrl_en <= hwdata[`GPIB_C_SVC];
      end
      if (addr_wr) begin
        addr_r <= hwdata[`GPIB_C_ADDR_LSB +: 5];
        if (svc_mode_r)
          svc_ctrl_en <= 1'b0;
      end
      if (wr && wa_r == `GPIB_A_TXD)
        txd_r <= hwdata[7:0];
      if (wr && wa_r == `GPIB_A_MASK)
        mask_r <= hwdata[NCOND-1:0];
    end
  end

  // ------------------------------------------------------------
  // Command decode and interface state
  // ------------------------------------------------------------
  wire cmd = rx_full & rx_cmd & ~lon;
  wire [6:0] cb = rx_byte[6:0];
  wire my_lag = cmd & (cb[6:5] == `GPIB_GRP_LAG) & (cb[4:0] == addr_r);
  wire my_tag = cmd & (cb[6:5] == `GPIB_GRP_TAG) & (cb[4:0] == addr_r);
  wire oth_tag = cmd & (cb[6:5] == `GPIB_GRP_TAG) & (cb[4:0] != addr_r);
  wire c_unl = cmd & (cb == `GPIB_CMD_UNL);
  wire c_dcl = cmd & (cb == `GPIB_CMD_DCL);
  wire c_sdc = cmd & (cb == `GPIB_CMD_SDC) & lads_r & ren_eff;
  wire c_gtl = cmd & (cb == `GPIB_CMD_GTL) & lads_r & ren_eff;
  wire c_llo = cmd & (cb == `GPIB_CMD_LLO);
  wire clr = c_dcl | c_sdc;
  wire sb_done = spms_r & tads_r & ~tx_busy & sb_sent_r;
  wire atn_in_cmd = ~atn_n;
  wire tx_go_serial = spms_r & tads_r & ~tx_busy & ~sb_sent_r & ~atn_in_cmd;
  assign rx_take = rx_full & (rx_cmd | lon ? 1'b1 : rxd_rd) | (rx_full & clr);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lads_r <= 1'b0;
      tads_r <= 1'b0;
      spms_r <= 1'b0;
      rem_r <= 1'b0;
      llo_r <= 1'b0;
      dev_clear <= 1'b0;
      sb_sent_r <= 1'b0;
    end else if (ce) begin
      dev_clear <= clr;
      if (ifc_eff) begin
        lads_r <= 1'b0;
        tads_r <= 1'b0;
        spms_r <= 1'b0;
      end else begin
        if (my_lag) begin
          lads_r <= 1'b1;
          tads_r <= 1'b0;
        end else if (c_unl)
          lads_r <= 1'b0;
        if (my_tag) begin
          tads_r <= 1'b1;
          lads_r <= 1'b0;
        end else if (oth_tag || (cmd && cb == `GPIB_CMD_UNT))
          tads_r <= 1'b0;
        if (clr || c_gtl)
          tads_r <= 1'b0;
        if (cmd && cb == `GPIB_CMD_SPE)
          spms_r <= 1'b1;
        if (cmd && cb == `GPIB_CMD_SPD)
          spms_r <= 1'b0;
      end
      if (!ren_eff) begin
        rem_r <= 1'b0;
        llo_r <= 1'b0;
      end else begin
        if (my_lag)
          rem_r <= 1'b1;
        if (c_gtl)
          rem_r <= 1'b0;
        else if (local_key && !llo_r)
          rem_r <= 1'b0;
        if (c_llo)
          llo_r <= 1'b1;
      end
      if (tx_go_serial)
        sb_sent_r <= 1'b1;
      else if (!spms_r || !tads_r)
        sb_sent_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Service request and status byte
  // ------------------------------------------------------------
  // Pending conditions latch; a set arriving with a clear write wins.
  wire [NCOND-1:0] cond_clr = (wr && wa_r == `GPIB_A_COND) ? hwdata[NCOND-1:0]
                                                          : {NCOND{1'b0}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_r <= {NCOND{1'b0}};
      rqs_r <= 1'b0;
    end else if (ce) begin
      cond_r <= (cond_r & ~cond_clr) | cond_set;
      if (srq_want && !lon)
        rqs_r <= 1'b1;
      else if (sb_done || !srq_want)
        rqs_r <= srq_want & ~sb_done;
    end
  end

  // ------------------------------------------------------------
  // Handshakes
  // ------------------------------------------------------------
  // Acceptor runs for commands (attention) and data while listening.
  gpib_hs_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .enable(atn_in_cmd | listen_w),
    .dav_n(dav_n_in),
    .dio_n(dio_n_in),
    .atn_n(atn_n | lon),
    .take(rx_take),
    .nrfd_oe(nrfd_oe),
    .ndac_oe(ndac_oe),
    .byte_r(rx_byte),
    .cmd_r(rx_cmd),
    .full_r(rx_full)
  );

  gpib_hs_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .enable(tads_r & atn_n & ~ifc_eff & ~clr),
    .go(tx_go_serial | (tx_go_r & ~spms_r)),
    .data(spms_r ? stb : txd_r),
    .eoi(spms_r ? 1'b0 : tx_eoi_r),
    .nrfd_n(nrfd_n_in),
    .ndac_n(ndac_n_in),
    .dav_oe(dav_oe),
    .eoi_oe(eoi_oe),
    .dio_oe(tx_dio_oe),
    .busy(tx_busy)
  );

  // Open-collector style lines: value low, enable selects drive.
  assign dio_n_out = 8'h00;
  assign dio_n_oe = tx_dio_oe;
  assign dav_n_out = 1'b0;
  assign dav_n_oe = dav_oe;
  assign eoi_n_out = 1'b0;
  assign eoi_n_oe = eoi_oe;
  assign nrfd_n_out = 1'b0;
  assign nrfd_n_oe = nrfd_oe;
  assign ndac_n_out = 1'b0;
  assign ndac_n_oe = ndac_oe;
  assign srq_n_out = 1'b0;
  assign srq_n_oe = rqs_r & ~lon;
  assign remote = rem_r;
  assign listen = listen_w;
  assign talk = tads_r;
  assign panel_enable = ~rem_r;
endmodule // gpib_dev

// ---- verification/gpib_dev_props.sv ----
// Concurrent checks on the bus device ports.
`timescale 1ns/1ps
module gpib_dev_props (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire dav_n_oe,
  input wire srq_n_out,
  input wire atn_n,
  input wire ifc_n,
  input wire ren_n,
  input wire remote,
  input wire listen,
  input wire talk,
  input wire panel_enable,
  input wire dev_clear
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Input synchronisers may take a few cycles, so levels are judged after a held input.
  sequence s_ren_off; ren_n [*5]; endsequence
  sequence s_ifc_on; !ifc_n [*4]; endsequence
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus response not zero-wait OKAY");
  property p_ren; s_ren_off |-> !remote; endproperty
  a_ren: assert property (p_ren) else $error("remote without remote enable");
  property p_panel; remote |-> !panel_enable; endproperty
  a_panel: assert property (p_panel) else $error("panel live in remote");
  property p_excl; !(talk && listen); endproperty
  a_excl: assert property (p_excl) else $error("talker and listener at once");
  property p_ifc; s_ifc_on |-> !talk; endproperty
  a_ifc: assert property (p_ifc) else $error("still talking under interface clear");
  property p_clr; $rose(dev_clear) |=> !dev_clear; endproperty
  a_clr: assert property (p_clr) else $error("device clear not one cycle");
  property p_src; $rose(dav_n_oe) |-> talk && atn_n; endproperty
  a_src: assert property (p_src) else $error("byte sourced while not talker");
  property p_srq; srq_n_out == 1'b0; endproperty
  a_srq: assert property (p_srq) else $error("request line driven high");
endmodule // gpib_dev_props
bind gpib_dev gpib_dev_props u_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .dav_n_oe(dav_n_oe), .srq_n_out(srq_n_out), .atn_n(atn_n), .ifc_n(ifc_n),
  .ren_n(ren_n), .remote(remote), .listen(listen), .talk(talk), .panel_enable(panel_enable),
  .dev_clear(dev_clear));

// ---- verification/gpib_ctl_model.sv ----
// Bus controller model: sources commands and data, accepts talker bytes.
`timescale 1ns/1ps
module gpib_ctl_model (
  input wire hclk,
  input wire [7:0] dio_n,
  input wire dav_n,
  input wire nrfd_n,
  input wire ndac_n,
  output reg [7:0] dio_oe,
  output reg dav_oe,
  output reg nrfd_oe,
  output reg ndac_oe,
  output reg atn_n,
  output reg ifc_n,
  output reg ren_n,
  output reg fault
);
  integer slow;
  initial begin
    dio_oe = 8'h00; dav_oe = 0; nrfd_oe = 0; ndac_oe = 0;
    atn_n = 1; ifc_n = 1; ren_n = 1; fault = 0; slow = 0;
  end
  task wait_line(input [1:0] sel, input v);
    integer t;
    begin
      t = 0;
      @(posedge hclk);
      while ((sel == 0 ? nrfd_n : sel == 1 ? ndac_n : dav_n) !== v && t < 2000) begin
        @(posedge hclk);
        t = t + 1;
      end
      if (t >= 2000) fault <= 1'b1;
    end
  endtask
  // Source side; a wire pulled low reads as a one.
  task send(input [7:0] b, input cmd);
    begin
      @(posedge hclk);
      atn_n <= ~cmd;
      nrfd_oe <= 1'b0;
      ndac_oe <= 1'b0;
      dio_oe <= b;
      wait_line(1, 1'b0);
      wait_line(0, 1'b1);
      repeat (slow) @(posedge hclk);
      dav_oe <= 1'b1;
      wait_line(1, 1'b1);
      dav_oe <= 1'b0;
      dio_oe <= 8'h00;
    end
  endtask
  // Acceptor side; holds off further bytes when done.
  task recv(output [7:0] b);
    begin
      @(posedge hclk);
      atn_n <= 1'b1;
      ndac_oe <= 1'b1;
      nrfd_oe <= 1'b0;
      wait_line(2, 1'b0);
      b = ~dio_n;
      nrfd_oe <= 1'b1;
      repeat (slow) @(posedge hclk);
      ndac_oe <= 1'b0;
      wait_line(2, 1'b1);
      ndac_oe <= 1'b1;
    end
  endtask
endmodule // gpib_ctl_model

// ---- verification/gpib_dev_tb.sv ----
// Self-checking bench for the bus device interface.
`timescale 1ns/1ps
`include "gpib_defs.vh"
module gpib_dev_tb;
  reg hclk, hresetn, backup_valid, local_key, hwrite;
  reg [31:0] haddr, hwdata, q;
  reg [1:0] htrans;
  reg [4:0] my_addr;
  reg [4:0] addr_switch;
  reg [6:0] cond_set;
  reg [7:0] b, rb;
  wire [31:0] hrdata;
  wire hreadyout, remote, listen, talk, panel_enable, dev_clear, svc_ctrl_en, srq_n_oe;
  wire [7:0] d_dio_oe, c_dio_oe;
  wire d_dav_oe, d_nrfd_oe, d_ndac_oe, d_eoi_oe, c_dav_oe, c_nrfd_oe, c_ndac_oe;
  wire atn_n, ifc_n, ren_n, c_fault;
  wire [7:0] dio_n = ~(d_dio_oe | c_dio_oe);
  wire dav_n = ~(d_dav_oe | c_dav_oe);
  wire nrfd_n = ~(d_nrfd_oe | c_nrfd_oe);
  wire ndac_n = ~(d_ndac_oe | c_ndac_oe);
  integer n_errors = 0, total_checks = 0, n_clr = 0, k;
  gpib_dev u_gpib_dev (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .backup_valid(backup_valid),
    .addr_switch(addr_switch), .local_key(local_key), .cond_set(cond_set),
    .dio_n_in(dio_n), .dio_n_out(), .dio_n_oe(d_dio_oe), .dav_n_in(dav_n), .dav_n_out(),
    .dav_n_oe(d_dav_oe), .nrfd_n_in(nrfd_n), .nrfd_n_out(), .nrfd_n_oe(d_nrfd_oe),
    .ndac_n_in(ndac_n), .ndac_n_out(), .ndac_n_oe(d_ndac_oe), .eoi_n_in(~d_eoi_oe),
    .eoi_n_out(), .eoi_n_oe(d_eoi_oe), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n),
    .srq_n_out(), .srq_n_oe(srq_n_oe), .remote(remote), .listen(listen), .talk(talk),
    .panel_enable(panel_enable), .dev_clear(dev_clear), .svc_ctrl_en(svc_ctrl_en));
  gpib_ctl_model u_ctl (.hclk(hclk), .dio_n(dio_n), .dav_n(dav_n), .nrfd_n(nrfd_n),
    .ndac_n(ndac_n), .dio_oe(c_dio_oe), .dav_oe(c_dav_oe), .nrfd_oe(c_nrfd_oe),
    .ndac_oe(c_ndac_oe), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n), .fault(c_fault));
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) if (dev_clear === 1'b1) n_clr <= n_clr + 1;
  function [7:0] lag(input [4:0] a); lag = {3'b001, a}; endfunction
  function [7:0] tag(input [4:0] a); tag = {3'b010, a}; endfunction
  function [7:0] stb(input [6:0] c); stb = {c[6], 1'b1, c[5:0]}; endfunction
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task ahb(input w, input [3:0] idx, input [31:0] d);
    begin
      @(posedge hclk);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {26'h0, idx, 2'h0};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
    end
  endtask
  task rdc(input string name, input [3:0] idx, input [31:0] m, input [31:0] exp);
    begin
      ahb(1'b0, idx, 32'h0);
      chk(name, q & m, exp);
    end
  endtask
  task do_reset(input bv, input [4:0] sw);
    begin
      hresetn <= 1'b0;
      backup_valid <= bv;
      addr_switch <= sw;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
    end
  endtask
  task idle;
    repeat (6) @(posedge hclk);
  endtask
  task pulse_cond(input [6:0] c);
    begin
      @(posedge hclk);
      cond_set <= c;
      @(posedge hclk);
      cond_set <= 7'h00;
      idle;
    end
  endtask
  task end_of_test;
    begin
      $display("Checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #(8 * 60000);
    n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    hresetn = 0; backup_valid = 1; addr_switch = 5'h00; local_key = 0; cond_set = 7'h00;
    htrans = 2'h0; hwrite = 0; haddr = 32'h0; hwdata = 32'h0;
    k = $urandom(32'h955f3ae5);
    do_reset(1'b1, 5'h00);
    chk("panel_rst", panel_enable, 1);
    rdc("addr_fact", `GPIB_A_ADDR, 32'h1F, `GPIB_ADDR_FACT);
    ahb(1'b1, 4'h9, 32'hFFFFFFFF);
    rdc("unmapped", 4'h9, 32'hFFFFFFFF, 32'h0);
    my_addr = $urandom % 31;
    do_reset(1'b0, my_addr);
    rdc("addr_sw", `GPIB_A_ADDR, 32'h1F, my_addr);
    u_ctl.ren_n <= 1'b0;
    u_ctl.send(lag(my_addr == 5'h1E ? 5'h00 : my_addr + 5'h01), 1'b1);
    idle;
    chk("listen_other", listen, 0);
    u_ctl.send(lag(my_addr), 1'b1);
    idle;
    chk("listen", listen, 1);
    chk("remote", remote, 1);
    chk("panel_rmt", panel_enable, 0);
    for (k = 0; k < 3; k = k + 1) begin
      b = $urandom;
      u_ctl.slow = k * 3;
      u_ctl.send(b, 1'b0);
      rdc("rxd", `GPIB_A_RXD, 32'hFF, b);
    end
    u_ctl.send($urandom, 1'b0);
    u_ctl.send(`GPIB_CMD_SDC, 1'b1);
    idle;
    chk("sdc_pulse", n_clr, 1);
    rdc("sdc_drop", `GPIB_A_STAT, 32'h40, 32'h0);
    local_key <= 1'b1;
    idle;
    local_key <= 1'b0;
    idle;
    chk("key_local", remote, 0);
    u_ctl.send(lag(my_addr), 1'b1);
    u_ctl.send(`GPIB_CMD_GTL, 1'b1);
    idle;
    chk("gtl", remote, 0);
    u_ctl.send(`GPIB_CMD_LLO, 1'b1);
    u_ctl.send(lag(my_addr), 1'b1);
    idle;
    rdc("llo", `GPIB_A_STAT, 32'h30, 32'h30);
    local_key <= 1'b1;
    idle;
    local_key <= 1'b0;
    idle;
    chk("key_locked", remote, 1);
    u_ctl.ren_n <= 1'b1;
    idle;
    rdc("ren_off", `GPIB_A_STAT, 32'h30, 32'h0);
    u_ctl.send(tag(my_addr), 1'b1);
    idle;
    chk("talk", {talk, listen}, 2'b10);
    b = $urandom;
    ahb(1'b1, `GPIB_A_TXD, b);
    // Attention must be released before the send strobe, or the strobe is lost.
    fork
      u_ctl.recv(rb);
      ahb(1'b1, `GPIB_A_CTRL, 32'h1 << `GPIB_C_TXGO);
    join
    chk("txd", rb, b);
    k = $urandom % 7;
    ahb(1'b1, `GPIB_A_MASK, 32'h0);
    pulse_cond(7'h01 << k);
    chk("srq_masked", srq_n_oe, 0);
    ahb(1'b1, `GPIB_A_COND, 32'h7F);
    ahb(1'b1, `GPIB_A_MASK, 32'h7F);
    pulse_cond(7'h01 << k);
    chk("srq", srq_n_oe, 1);
    u_ctl.send(`GPIB_CMD_SPE, 1'b1);
    u_ctl.send(tag(my_addr), 1'b1);
    u_ctl.recv(rb);
    chk("stb", rb, stb(7'h01 << k));
    u_ctl.send(`GPIB_CMD_SPD, 1'b1);
    u_ctl.send(`GPIB_CMD_DCL, 1'b1);
    idle;
    chk("dcl", {talk, n_clr[1:0]}, 3'b010);
    rdc("dcl_keep", `GPIB_A_MASK, 32'h7F, 32'h7F);
    u_ctl.send(lag(my_addr), 1'b1);
    u_ctl.ifc_n <= 1'b0;
    repeat (6) @(posedge hclk);
    u_ctl.ifc_n <= 1'b1;
    idle;
    chk("ifc", listen, 0);
    ahb(1'b1, `GPIB_A_CTRL, 32'h1 << `GPIB_C_SVC);
    idle;
    chk("svc_on", svc_ctrl_en, 1);
    ahb(1'b1, `GPIB_A_CTRL, {19'h0, `GPIB_ADDR_LON, 8'h03});
    idle;
    chk("svc_off", svc_ctrl_en, 0);
    chk("lon", {listen, panel_enable}, 2'b11);
    b = $urandom;
    // Clear and remote enable stay released here; the send releases attention.
    u_ctl.send(b, 1'b0);
    rdc("lon_rxd", `GPIB_A_RXD, 32'hFF, b);
    chk("ctl_fault", c_fault, 0);
    end_of_test;
  end
endmodule // gpib_dev_tb
